// ---- verilog/monitor_adc_conversion_control.sv ----
// What this block does
// (R1) start taken only with mode bit set in the same write
// (R2) manual channel comes from select register
// (R3) channel 0 drives configured current source
// (R4) converter powered on request, or kept on
// (R5) manual done interrupt gated by mask
// (R6) manual start bit begins one conversion
// (R7) manual completion sets manual done flag
// (R8) 12-bit result split high nibble, low byte
// (R9) slot 0 converts its selected channel
// (R10) periodic rate follows rate field
// (R11) slot 0 result compared to 12-bit limit
// (R12) direction bit picks above or below
// (R13) poweroff bit makes trip request shutdown
// (R14) slot 0 event interrupt gated by mask
// (R15) slot 0 runs only while enabled
// (R16) slot 0 crossing sets its event flag
// (R17) slot 0 result stored in result registers
// (R18) poweroff after grace unless event cleared
// (R19) second slot behaves like slot 0
// (R20) results held until next same-mode conversion
`timescale 1ns/100ps
`default_nettype none
module monitor_adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    // cycles per rate unit, shorten in simulation
    parameter int unsigned RATE_CYCLES = RATE_UNIT_CYCLES,
    // cycles of the poweroff grace delay, shorten in simulation
    parameter int unsigned GRACE_LEN = GRACE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output conv_cmd_t conv_cmd,
    input wire conv_ans_t conv_ans,
    output logic conv_power,
    output logic [2:0] current_source_level,
    output logic irq_out,
    output logic poweroff_request
);
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY
    } seq_state_t;

    // software-visible configuration
    logic mode_en_reg;
    logic [3:0] man_ch_reg;
    logic keep_on_reg;
    logic [2:0] cur_src_reg;
    logic [2:0] mask_reg;
    logic [2:0] flags_reg;
    logic [11:0] man_res_reg;
    logic [3:0] slot_ch_reg [2];
    logic [3:0] rate_reg;
    logic [1:0] slot_en_reg;
    logic [1:0] slot_poff_reg;
    logic [11:0] limit_reg [2];
    logic [1:0] dir_reg;
    logic [11:0] slot_res_reg [2];
    // sequencer and pending work
    seq_state_t state_reg;
    logic man_pend_reg;
    logic [1:0] slot_pend_reg;
    logic [1:0] src_reg;
    logic [3:0] ch_reg;
    logic start_reg;
    // periodic timers
    logic [31:0] unit_cnt_reg;
    logic [3:0] rate_cnt_reg;
    logic period_pulse;
    // grace counters and shutdown
    logic [31:0] grace_cnt_reg [2];
    logic [1:0] grace_arm_reg;
    logic poff_reg;
    logic [2:0] cur_out_reg;
    logic [31:0] rdata_reg;
    // bus decode
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic man_start;
    logic [1:0] trip;
    logic done_man;
    logic [1:0] done_slot;

    // zero wait state slave, error on unmapped address
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = rdata_reg;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr < (SLOT_BASE_OFS + 8'(2 * SLOT_STRIDE)));
    // (R1) start gated by mode
    assign man_start = wr_en && (paddr == MANUAL_SELECT_OFS) && pwdata[MAN_START_BIT]
        && pwdata[MODE_EN_BIT];
    assign flag_clr = (wr_en && (paddr == INT_FLAGS_OFS)) ? pwdata[2:0] : 3'h0;

    // completion decode by source
    assign done_man = (state_reg == ST_BUSY) && conv_ans.done && (src_reg == 2'h0);

    // per-slot completion and threshold compare
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_slot
            assign done_slot[gi] = (state_reg == ST_BUSY) && conv_ans.done
                && (src_reg == 2'(gi + 1));
            // (R12) direction picks compare
            assign trip[gi] = done_slot[gi] && (dir_reg[gi] ? (conv_ans.code > limit_reg[gi])
                : (conv_ans.code < limit_reg[gi]));
        end
    endgenerate

    // (R7) manual and slot flag sets
    assign flag_set = {trip[1], trip[0], done_man};

    // manual select and control one registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_en_reg <= 1'b0;
            man_ch_reg <= 4'h0;
            keep_on_reg <= 1'b0;
            cur_src_reg <= 3'h0;
        end else if (wr_en) begin
            // (R2) channel field write
            if (paddr == MANUAL_SELECT_OFS) begin
                mode_en_reg <= pwdata[MODE_EN_BIT];
                man_ch_reg <= pwdata[MAN_CH_LSB +: 4];
            end
            if (paddr == CONTROL_ONE_OFS) begin
                keep_on_reg <= pwdata[KEEP_ON_BIT];
                cur_src_reg <= pwdata[CUR_SRC_LSB +: 3];
            end
        end
    end

    // mask and periodic configuration registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mask_reg <= MASK_RESET;
            rate_reg <= RATE_RESET;
            slot_en_reg <= 2'h0;
            slot_poff_reg <= 2'h0;
            slot_ch_reg[0] <= 4'h0;
            slot_ch_reg[1] <= 4'h0;
        end else if (wr_en) begin
            if (paddr == INT_MASK_OFS) begin
                mask_reg <= pwdata[2:0];
            end
            // (R9) slot channel write
            if (paddr == PERIODIC_SELECT_OFS) begin
                slot_ch_reg[0] <= pwdata[3:0];
                slot_ch_reg[1] <= pwdata[7:4];
            end
            if (paddr == PERIODIC_CONTROL_OFS) begin
                rate_reg <= pwdata[RATE_LSB +: 4];
                slot_en_reg <= pwdata[SLOT_EN_LSB +: 2];
                slot_poff_reg <= pwdata[SLOT_POFF_LSB +: 2];
            end
        end
    end

    // limit registers, one pair per slot
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                limit_reg[i] <= 12'h000;
                dir_reg[i] <= 1'b0;
            end
        end else if (wr_en) begin
            for (int i = 0; i < 2; i++) begin
                // (R11) limit high nibble, direction
                if (paddr == SLOT_BASE_OFS + 8'(i * SLOT_STRIDE) + LIMIT_HIGH_SUB) begin
                    limit_reg[i][11:8] <= pwdata[3:0];
                    dir_reg[i] <= pwdata[DIR_BIT];
                end
                if (paddr == SLOT_BASE_OFS + 8'(i * SLOT_STRIDE) + LIMIT_LOW_SUB) begin
                    limit_reg[i][7:0] <= pwdata[7:0];
                end
            end
        end
    end

    // sticky event flags, write one to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flags_reg <= 3'h0;
        end else begin
            // (R16) crossing sets flag
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    // (R5) (R14) masked events onto interrupt
    assign irq_out = |(flags_reg & ~mask_reg);

    // result registers, held until next conversion of same mode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            man_res_reg <= 12'h000;
            slot_res_reg[0] <= 12'h000;
            slot_res_reg[1] <= 12'h000;
        end else begin
            // (R20) (R8) manual result store
            if (done_man) begin
                man_res_reg <= conv_ans.code;
            end
            // (R17) (R19) slot result store
            for (int i = 0; i < 2; i++) begin
                if (done_slot[i]) begin
                    slot_res_reg[i] <= conv_ans.code;
                end
            end
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            rdata_reg <= 32'h0000_0000;
            case (paddr)
                MANUAL_SELECT_OFS: rdata_reg <= {26'h0, man_pend_reg, man_ch_reg, mode_en_reg};
                CONTROL_ONE_OFS: rdata_reg <= {28'h0, cur_src_reg, keep_on_reg};
                INT_MASK_OFS: rdata_reg <= {29'h0, mask_reg};
                INT_FLAGS_OFS: rdata_reg <= {29'h0, flags_reg};
                MANUAL_RES_HIGH_OFS: rdata_reg <= {28'h0, man_res_reg[11:8]};
                MANUAL_RES_LOW_OFS: rdata_reg <= {24'h0, man_res_reg[7:0]};
                PERIODIC_SELECT_OFS: rdata_reg <= {24'h0, slot_ch_reg[1], slot_ch_reg[0]};
                PERIODIC_CONTROL_OFS: rdata_reg <= {24'h0, slot_poff_reg, slot_en_reg, rate_reg};
                default: begin
                    // slot registers
                    for (int i = 0; i < 2; i++) begin
                        if (paddr == SLOT_BASE_OFS + 8'(i * SLOT_STRIDE) + LIMIT_HIGH_SUB) begin
                            rdata_reg <= {24'h0, dir_reg[i], 3'h0, limit_reg[i][11:8]};
                        end
                        if (paddr == SLOT_BASE_OFS + 8'(i * SLOT_STRIDE) + LIMIT_LOW_SUB) begin
                            rdata_reg <= {24'h0, limit_reg[i][7:0]};
                        end
                        if (paddr == SLOT_BASE_OFS + 8'(i * SLOT_STRIDE) + RESULT_HIGH_SUB) begin
                            rdata_reg <= {28'h0, slot_res_reg[i][11:8]};
                        end
                        if (paddr == SLOT_BASE_OFS + 8'(i * SLOT_STRIDE) + RESULT_LOW_SUB) begin
                            rdata_reg <= {24'h0, slot_res_reg[i][7:0]};
                        end
                    end
                end
            endcase
        end
    end

    // rate unit divider and period counter, run while any slot enabled
    always_ff @(posedge ref_clk) begin
        if (srst || (slot_en_reg == 2'h0)) begin
            unit_cnt_reg <= 32'h0000_0000;
            rate_cnt_reg <= 4'h0;
        end else if (unit_cnt_reg == 32'(RATE_CYCLES - 1)) begin
            unit_cnt_reg <= 32'h0000_0000;
            // (R10) rate field sets period
            rate_cnt_reg <= (rate_cnt_reg >= rate_reg) ? 4'h0 : rate_cnt_reg + 4'h1;
        end else begin
            unit_cnt_reg <= unit_cnt_reg + 32'h0000_0001;
        end
    end

    // one pulse per period of (rate + 1) units
    assign period_pulse = (unit_cnt_reg == 32'(RATE_CYCLES - 1)) && (rate_cnt_reg >= rate_reg);

    // pending work, dropped when a slot is disabled
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            man_pend_reg <= 1'b0;
            slot_pend_reg <= 2'h0;
        end else begin
            // (R6) start marks one conversion pending
            if (man_start) begin
                man_pend_reg <= 1'b1;
            end else if ((state_reg == ST_IDLE) && man_pend_reg) begin
                man_pend_reg <= 1'b0;
            end
            for (int i = 0; i < 2; i++) begin
                // (R15) slot runs only while enabled
                if (!slot_en_reg[i]) begin
                    slot_pend_reg[i] <= 1'b0;
                end else if (period_pulse) begin
                    slot_pend_reg[i] <= 1'b1;
                end else if ((state_reg == ST_IDLE) && !man_pend_reg
                        && (i == 0 || !slot_pend_reg[0])) begin
                    slot_pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // sequencer: manual first, then slot 0, then slot 1
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            src_reg <= 2'h0;
            ch_reg <= 4'h0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (man_pend_reg) begin
                        src_reg <= 2'h0;
                        ch_reg <= man_ch_reg;
                        start_reg <= 1'b1;
                        state_reg <= ST_BUSY;
                    end else if (slot_pend_reg[0]) begin
                        src_reg <= 2'h1;
                        ch_reg <= slot_ch_reg[0];
                        start_reg <= 1'b1;
                        state_reg <= ST_BUSY;
                    end else if (slot_pend_reg[1]) begin
                        src_reg <= 2'h2;
                        ch_reg <= slot_ch_reg[1];
                        start_reg <= 1'b1;
                        state_reg <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (conv_ans.done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // converter request and power
    assign conv_cmd = '{start: start_reg, channel: ch_reg};
    // (R4) power on request or keep-on
    assign conv_power = keep_on_reg || (state_reg == ST_BUSY) || start_reg;

    // current source output, only during a channel 0 conversion
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cur_out_reg <= 3'h0;
        end else begin
            // (R3) channel 0 current source
            cur_out_reg <= ((state_reg == ST_BUSY) && (ch_reg == 4'h0)) ? cur_src_reg : 3'h0;
        end
    end
    assign current_source_level = cur_out_reg;

    // grace counters per slot, cancelled when the event flag is cleared
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            grace_arm_reg <= 2'h0;
            grace_cnt_reg[0] <= 32'h0000_0000;
            grace_cnt_reg[1] <= 32'h0000_0000;
            poff_reg <= 1'b0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // (R13) trip arms shutdown, or re-arms one being cancelled
                if (trip[i] && slot_poff_reg[i]
                        && !(grace_arm_reg[i] && flags_reg[SLOT_EVT_LSB + i])) begin
                    grace_arm_reg[i] <= 1'b1;
                    grace_cnt_reg[i] <= 32'h0000_0000;
                // (R18) cleared event cancels shutdown
                end else if (grace_arm_reg[i] && !flags_reg[SLOT_EVT_LSB + i]) begin
                    grace_arm_reg[i] <= 1'b0;
                end else if (grace_arm_reg[i]) begin
                    if (grace_cnt_reg[i] == 32'(GRACE_LEN - 1)) begin
                        poff_reg <= 1'b1;
                    end else begin
                        grace_cnt_reg[i] <= grace_cnt_reg[i] + 32'h0000_0001;
                    end
                end
            end
        end
    end
    assign poweroff_request = poff_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // manual start leads to a start pulse on a manual source
    sequence man_req_s;
        man_start && state_reg == ST_IDLE && !man_pend_reg && slot_pend_reg == 2'h0;
    endsequence
    sequence man_go_s;
        ##2 start_reg && src_reg == 2'h0;
    endsequence
    man_start_go_a: assert property (man_req_s |-> man_go_s) // (R6)
        else $error("manual start did not begin a conversion");
    man_gate_a: assert property (wr_en && paddr == MANUAL_SELECT_OFS // (R1)
        && !pwdata[MODE_EN_BIT] && !man_pend_reg |=> !man_pend_reg)
        else $error("start accepted without manual mode");
    man_chan_a: assert property (start_reg && src_reg == 2'h0 |-> conv_cmd.channel // (R2)
        == $past(man_ch_reg))
        else $error("manual channel wrong");
    man_flag_a: assert property (done_man |=> flags_reg[MAN_DONE_BIT]) // (R7)
        else $error("manual done flag not set");
    irq_gate_a: assert property (done_man && !mask_reg[MAN_DONE_BIT] // (R5)
        && !(wr_en && paddr == INT_MASK_OFS) |=> irq_out)
        else $error("unmasked manual completion raised no interrupt");
    power_a: assert property (start_reg |-> conv_power ##1 conv_power) // (R4)
        else $error("converter not powered during conversion");
    trip_flag_a: assert property (trip[0] |=> flags_reg[SLOT_EVT_LSB]) // (R16)
        else $error("slot 0 event flag not set");
    slot_res_a: assert property (done_slot[1] |=> slot_res_reg[1] == $past(conv_ans.code)) // (R19)
        else $error("slot 1 result not stored");
    hold_res_a: assert property (!done_man |=> $stable(man_res_reg)) // (R20)
        else $error("manual result changed without conversion");
    slot_off_a: assert property (!slot_en_reg[0] |=> !slot_pend_reg[0]) // (R15)
        else $error("disabled slot still pending");
    cur_src_a: assert property (state_reg == ST_BUSY && ch_reg != 4'h0 |=> // (R3)
        current_source_level == 3'h0)
        else $error("current source on for other channel");
    poff_hold_a: assert property (!grace_arm_reg[0] && !grace_arm_reg[1] && !poff_reg // (R18)
        |=> !poff_reg)
        else $error("poweroff without armed grace delay");
endmodule : monitor_adc_conversion_control
`default_nettype wire

// ---- verilog/adc_ctrl_pkg.sv ----
`default_nettype none
package adc_ctrl_pkg;
    // clock period of ref_clk
    localparam int unsigned CLK_PERIOD_NS = 5;
    // unit of the periodic rate field, as a time
    localparam int unsigned RATE_UNIT_NS = 1000000;
    // unit of the periodic rate field, in cycles (exact division)
    localparam int unsigned RATE_UNIT_CYCLES = RATE_UNIT_NS / CLK_PERIOD_NS;
    // poweroff grace delay, as a time (least time, rounded up)
    localparam int unsigned GRACE_DELAY_NS = 10000000;
    localparam int unsigned GRACE_CYCLES = (GRACE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] MANUAL_SELECT_OFS = 8'h00;
    localparam logic [7:0] CONTROL_ONE_OFS = 8'h04;
    localparam logic [7:0] INT_MASK_OFS = 8'h08;
    localparam logic [7:0] INT_FLAGS_OFS = 8'h0C;
    localparam logic [7:0] MANUAL_RES_HIGH_OFS = 8'h10;
    localparam logic [7:0] MANUAL_RES_LOW_OFS = 8'h14;
    localparam logic [7:0] PERIODIC_SELECT_OFS = 8'h18;
    localparam logic [7:0] PERIODIC_CONTROL_OFS = 8'h1C;
    // slot registers: limit high, limit low, result high, result low per slot
    localparam logic [7:0] SLOT_BASE_OFS = 8'h20;
    localparam logic [7:0] SLOT_STRIDE = 8'h10;
    localparam logic [7:0] LIMIT_HIGH_SUB = 8'h00;
    localparam logic [7:0] LIMIT_LOW_SUB = 8'h04;
    localparam logic [7:0] RESULT_HIGH_SUB = 8'h08;
    localparam logic [7:0] RESULT_LOW_SUB = 8'h0C;

    // field positions
    localparam int unsigned MODE_EN_BIT = 0;
    localparam int unsigned MAN_CH_LSB = 1;
    localparam int unsigned MAN_START_BIT = 5;
    localparam int unsigned KEEP_ON_BIT = 0;
    localparam int unsigned CUR_SRC_LSB = 1;
    localparam int unsigned MAN_DONE_BIT = 0;
    localparam int unsigned SLOT_EVT_LSB = 1;
    localparam int unsigned RATE_LSB = 0;
    localparam int unsigned SLOT_EN_LSB = 4;
    localparam int unsigned SLOT_POFF_LSB = 6;
    localparam int unsigned DIR_BIT = 7;

    // values after reset
    localparam logic [2:0] MASK_RESET = 3'h7;
    localparam logic [3:0] RATE_RESET = 4'h0;

    // request to the analog converter
    typedef struct packed {
        logic start;
        logic [3:0] channel;
    } conv_cmd_t;

    // answer of the analog converter
    typedef struct packed {
        logic done;
        logic [11:0] code;
    } conv_ans_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ---- bench/monitor_adc_conversion_control_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module monitor_adc_conversion_control_tb
    import adc_ctrl_pkg::*;
;
    // shortened rate unit and grace delay
    localparam int unsigned RT = 20;
    localparam int unsigned GT = 50;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    conv_cmd_t conv_cmd;
    conv_ans_t conv_ans = '0;
    logic conv_power;
    logic [2:0] current_source_level;
    logic irq_out;
    logic poweroff_request;
    // expected {write, error, data} of each access
    logic [33:0] exp_q[$];
    logic [33:0] e;
    // code the converter answers with
    logic [11:0] resp_code = 12'h000;
    logic [11:0] code;
    logic [3:0] ch;
    int miscompares = 0;
    int total_checks = 0;
    int n;

    monitor_adc_conversion_control #(.RATE_CYCLES(RT), .GRACE_LEN(GT)) uut (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conv_cmd(conv_cmd), .conv_ans(conv_ans),
        .conv_power(conv_power), .current_source_level(current_source_level),
        .irq_out(irq_out), .poweroff_request(poweroff_request));

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%08h exp=%08h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // one apb transfer, expectation noted for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
        exp_q.push_back({w, err, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, d, 1'b0);
    endtask : rd

    // wait on {poweroff, irq, done, start} at falling edges, bounded
    task automatic wait_for(input logic [3:0] sel, input int lim, input logic hit);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((|(sel & {poweroff_request, irq_out, conv_ans.done, conv_cmd.start})) !== 1'b1
                   && n < lim);
        check(n < lim, hit);
    endtask : wait_for

    // monitor: compare each access with the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready) begin
            e = exp_q.pop_front();
            check(pslverr, e[32]);
            if (!e[33]) check(prdata, e[31:0]);
        end
    end

    // converter stand-in: answers each start after a random delay
    always @(posedge ref_clk) begin
        if (conv_cmd.start === 1'b1) begin
            repeat ($urandom_range(6, 1)) @(posedge ref_clk);
            conv_ans <= {1'b1, resp_code};
            @(posedge ref_clk);
            conv_ans <= {1'b0, ~resp_code};
        end
    end

    initial begin
        n = $urandom(75550);
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        check(conv_power, 1'b0);
        rd(INT_MASK_OFS, {29'h0, MASK_RESET});
        rd(PERIODIC_CONTROL_OFS, {28'h0, RATE_RESET});
        apb(1'b0, 8'h40, 32'h0, 1'b1);
        apb(1'b1, 8'h02, 32'hFF, 1'b1);
        $display("test reset done");
        // mode bit low: start ignored
        wr(MANUAL_SELECT_OFS, 32'h20);
        wait_for(4'h1, 20, 1'b0);
        @(posedge ref_clk);
        wr(CONTROL_ONE_OFS, 32'hA);
        for (int i = 0; i < 5; i++) begin
            ch = (i == 0) ? 4'h0 : 4'($urandom_range(15, 1));
            code = 12'($urandom);
            resp_code <= code;
            wr(MANUAL_SELECT_OFS, {26'h0, 1'b1, ch, 1'b1});
            wait_for(4'h1, 10, 1'b1);
            check(conv_cmd.channel, ch);
            @(negedge ref_clk);
            check(current_source_level, (ch == 4'h0) ? 3'h5 : 3'h0);
            check(conv_power, 1'b1);
            wait_for(4'h2, 20, 1'b1);
            @(negedge ref_clk);
            check(irq_out, i > 0);
            @(posedge ref_clk);
            rd(MANUAL_RES_HIGH_OFS, {28'h0, code[11:8]});
            rd(MANUAL_RES_LOW_OFS, {24'h0, code[7:0]});
            rd(INT_FLAGS_OFS, 32'h1);
            wr(INT_FLAGS_OFS, 32'h1);
            wr(INT_MASK_OFS, 32'h6);
        end
        // keep-on holds the converter powered
        check(conv_power, 1'b0);
        wr(CONTROL_ONE_OFS, 32'h1);
        @(negedge ref_clk);
        check(conv_power, 1'b1);
        @(posedge ref_clk);
        wr(CONTROL_ONE_OFS, 32'h0);
        $display("test manual done");
        // slot 0 above 0x800, slot 1 below 0x400 and masked
        wr(INT_MASK_OFS, 32'h4);
        wr(PERIODIC_SELECT_OFS, 32'h73);
        wr(SLOT_BASE_OFS, 32'h88);
        wr(SLOT_BASE_OFS + LIMIT_LOW_SUB, 32'h0);
        wr(SLOT_BASE_OFS + SLOT_STRIDE, 32'h04);
        wr(SLOT_BASE_OFS + SLOT_STRIDE + LIMIT_LOW_SUB, 32'h0);
        resp_code <= 12'h800;
        wr(PERIODIC_CONTROL_OFS, 32'h10);
        wait_for(4'h1, 60, 1'b1);
        check(conv_cmd.channel, 4'h3);
        wait_for(4'h1, 60, 1'b1);
        check(n, RT);
        check(irq_out, 1'b0);
        @(posedge ref_clk);
        resp_code <= 12'h801;
        wait_for(4'h4, 30, 1'b1);
        @(posedge ref_clk);
        wr(PERIODIC_CONTROL_OFS, 32'h0);
        rd(SLOT_BASE_OFS + RESULT_HIGH_SUB, 32'h8);
        rd(SLOT_BASE_OFS + RESULT_LOW_SUB, 32'h01);
        rd(INT_FLAGS_OFS, 32'h2);
        wr(INT_FLAGS_OFS, 32'h2);
        wait_for(4'h1, 60, 1'b0);
        @(posedge ref_clk);
        resp_code <= 12'h3FF;
        wr(PERIODIC_CONTROL_OFS, 32'h20);
        wait_for(4'h1, 60, 1'b1);
        check(conv_cmd.channel, 4'h7);
        wait_for(4'h2, 20, 1'b1);
        @(negedge ref_clk);
        check(irq_out, 1'b0);
        @(posedge ref_clk);
        wr(PERIODIC_CONTROL_OFS, 32'h0);
        rd(INT_FLAGS_OFS, 32'h4);
        rd(SLOT_BASE_OFS + SLOT_STRIDE + RESULT_LOW_SUB, 32'hFF);
        rd(MANUAL_RES_LOW_OFS, {24'h0, code[7:0]});
        wr(INT_FLAGS_OFS, 32'h4);
        $display("test periodic done");
        // trip with poweroff: cleared in time, then left to expire
        resp_code <= 12'h9AB;
        wr(INT_MASK_OFS, 32'h0);
        wr(PERIODIC_CONTROL_OFS, 32'h5F);
        wait_for(4'h4, 400, 1'b1);
        @(posedge ref_clk);
        wr(INT_FLAGS_OFS, 32'h2);
        wr(PERIODIC_CONTROL_OFS, 32'h4F);
        wait_for(4'h8, GT + 20, 1'b0);
        @(posedge ref_clk);
        wr(PERIODIC_CONTROL_OFS, 32'h5F);
        wait_for(4'h4, 400, 1'b1);
        wait_for(4'h8, GT + 5, 1'b1);
        check(n > GT - 5, 1'b1);
        $display("test poweroff done");
        // reset in mid-run clears the request
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        check(poweroff_request, 1'b0);
        check(irq_out, 1'b0);
        $display("test reset again done");
        wrap_up();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
endmodule : monitor_adc_conversion_control_tb
`default_nettype wire
